// ===== hw/iopc_core.sv
// Purpose: Four-port GPIO core on the CPU memory map
// Assumes: CPU request held from rd/wr strobe through S2; one access at a time
// Notes:   Read sampled in S1 and answered in S2, write takes effect in S2
`timescale 1ns/100ps
`include "iopc_cfg.svh"
module iopc_core
   import iopc_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire iopc_req_t              req,
   output      logic [`IOPC_DW-1:0]    rdata,
   output      logic                   rvalid,
   output      logic                   wdone,
   input  wire logic [`IOPC_P1_W-1:0]  port1_bit_zero_pin_i,
   output      logic [`IOPC_P1_W-1:0]  port1_bit_zero_pin_o,
   output      logic [`IOPC_P1_W-1:0]  port1_bit_zero_pin_oe,
   output      logic                   external_irq_zero,
   output      logic                   ext_irq_pin_select,
   input  wire logic [`IOPC_P3_W-1:0]  port3_pin_i,
   output      logic [`IOPC_P3_W-1:0]  port3_pin_o,
   output      logic [`IOPC_P3_W-1:0]  port3_pin_oe,
   input  wire logic [`IOPC_P4_W-1:0]  port4_pin_i,
   output      logic [`IOPC_P4_W-1:0]  port4_pin_o,
   output      logic [`IOPC_P4_W-1:0]  port4_pin_oe,
   input  wire logic [`IOPC_P6_W-1:0]  port6_pin_i,
   output      logic [`IOPC_P6_W-1:0]  port6_pin_o,
   output      logic [`IOPC_P6_W-1:0]  port6_pin_oe
);
   iopc_state_t         state_ff, nxt_state;
   iopc_req_t           hold_ff, nxt_hold;
   logic [`IOPC_DW-1:0] rdata_ff, nxt_rdata;
   logic                irqsel_ff, nxt_irqsel;
   logic [3:0]          latch_we, dir_we, od_we;
   logic [`IOPC_DW-1:0] pin_in [4];
   logic [`IOPC_DW-1:0] lat_q [4];
   logic [`IOPC_DW-1:0] dir_q [4];
   logic [`IOPC_DW-1:0] od_q [4];
   logic [`IOPC_DW-1:0] syn_q [4];
   iopc_drv_t           drv_q [4];
   logic                s2_wr;

   // Map an address to a port index for data, direction, open-drain
   function automatic logic [2:0] data_idx(input logic [`IOPC_AW-1:0] a);
      if (a == `IOPC_A_P1DATA) data_idx = 3'h0;
      else if (a == `IOPC_A_P3DATA) data_idx = 3'h1;
      else if (a == `IOPC_A_P4DATA) data_idx = 3'h2;
      else if (a == `IOPC_A_P6DATA) data_idx = 3'h3;
      else data_idx = 3'h4;
   endfunction : data_idx

   function automatic logic [2:0] dir_idx(input logic [`IOPC_AW-1:0] a);
      if (a == `IOPC_A_P1DIR) dir_idx = 3'h0;
      else if (a == `IOPC_A_P3DIR) dir_idx = 3'h1;
      else if (a == `IOPC_A_P4DIR) dir_idx = 3'h2;
      else if (a == `IOPC_A_P6DIR) dir_idx = 3'h3;
      else dir_idx = 3'h4;
   endfunction : dir_idx

   // Narrow ports read zero in their unused upper bits
   function automatic logic [`IOPC_DW-1:0] port_mask(input logic [1:0] i);
      if (i == 2'h0) port_mask = {`IOPC_DW{1'b1}} >> (`IOPC_DW - `IOPC_P1_W);
      else if (i == 2'h1) port_mask = {`IOPC_DW{1'b1}} >> (`IOPC_DW - `IOPC_P3_W);
      else if (i == 2'h2) port_mask = {`IOPC_DW{1'b1}} >> (`IOPC_DW - `IOPC_P4_W);
      else port_mask = {`IOPC_DW{1'b1}} >> (`IOPC_DW - `IOPC_P6_W);
   endfunction : port_mask

   function automatic logic [2:0] od_idx(input logic [`IOPC_AW-1:0] a);
      if (a == `IOPC_A_PORT3_OPEN_DRAIN_SELECT) od_idx = 3'h1;
      else if (a == `IOPC_A_PORT4_OPEN_DRAIN_SELECT) od_idx = 3'h2;
      else od_idx = 3'h4;
   endfunction : od_idx

   assign pin_in[0] = {{(`IOPC_DW-`IOPC_P1_W){1'b0}}, port1_bit_zero_pin_i};
   assign pin_in[1] = port3_pin_i;
   assign pin_in[2] = {{(`IOPC_DW-`IOPC_P4_W){1'b0}}, port4_pin_i};
   assign pin_in[3] = {{(`IOPC_DW-`IOPC_P6_W){1'b0}}, port6_pin_i};

   // Access sequencer: S1 samples, S2 writes
   always_comb
   begin
      nxt_state = state_ff;
      nxt_hold  = hold_ff;
      case (state_ff)
         IOPC_IDLE:
            if (req.rd | req.wr)
            begin
               nxt_hold  = req;
               nxt_state = IOPC_S1;
            end
         IOPC_S1: nxt_state = IOPC_S2;
         IOPC_S2: nxt_state = IOPC_S3;
         default: nxt_state = IOPC_IDLE;
      endcase
   end

   assign s2_wr = (state_ff == IOPC_S2) & hold_ff.wr; // [R5]

   genvar p;
   generate
      for (p = 0; p < 4; p++)
      begin : g_port
         assign latch_we[p] = s2_wr & (data_idx(hold_ff.addr) == 3'(p));
         assign dir_we[p]   = s2_wr & (dir_idx(hold_ff.addr) == 3'(p));
         assign od_we[p]    = s2_wr & (od_idx(hold_ff.addr) == 3'(p));
         iopc_port u_port (
            .clk      (clk),
            .rst      (rst),
            .latch_we (latch_we[p]),
            .dir_we   (dir_we[p]),
            .od_we    (od_we[p]),
            .wdata    (hold_ff.wdata),
            .pin_i    (pin_in[p]),
            .latch_q  (lat_q[p]),
            .dir_q    (dir_q[p]),
            .od_q     (od_q[p]),
            .pin_sync (syn_q[p]),
            .drv      (drv_q[p])
         );
      end
   endgenerate

   // Read mux, sampled in S1 only
   always_comb
   begin
      logic [2:0] di;
      logic [2:0] ci;
      logic [2:0] oi;
      logic [`IOPC_DW-1:0] v;
      di = data_idx(hold_ff.addr);
      ci = dir_idx(hold_ff.addr);
      oi = od_idx(hold_ff.addr);
      v  = `IOPC_ZERO_BYTE;
      if (di != 3'h4)
         v = (hold_ff.rmw ? lat_q[di[1:0]] : syn_q[di[1:0]]) & port_mask(di[1:0]); // [R2] [R6] [R7]
      else if (ci != 3'h4)
         v = dir_q[ci[1:0]] & port_mask(ci[1:0]);
      else if (oi != 3'h4)
         v = od_q[oi[1:0]] & port_mask(oi[1:0]);
      else if (hold_ff.addr == `IOPC_A_IRQSEL)
         v[`IOPC_IRQSEL_BIT] = irqsel_ff;
      nxt_rdata = ((state_ff == IOPC_S1) & hold_ff.rd) ? v : rdata_ff; // [R4]
      nxt_irqsel = (s2_wr & (hold_ff.addr == `IOPC_A_IRQSEL)) ?
                   hold_ff.wdata[`IOPC_IRQSEL_BIT] : irqsel_ff;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_ff  <= IOPC_IDLE;
         hold_ff   <= '0;
         rdata_ff  <= `IOPC_RST_BYTE;
         irqsel_ff <= 1'b0;
      end
      else
      begin
         state_ff  <= nxt_state;
         hold_ff   <= nxt_hold;
         rdata_ff  <= nxt_rdata;
         irqsel_ff <= nxt_irqsel;
      end
   end

   assign rdata  = rdata_ff;
   assign rvalid = (state_ff == IOPC_S2) & hold_ff.rd;
   assign wdone  = (state_ff == IOPC_S3) & hold_ff.wr;

   // Pin drivers, widths per port
   assign port1_bit_zero_pin_o  = drv_q[0].o[`IOPC_P1_W-1:0];
   assign port1_bit_zero_pin_oe = drv_q[0].oe[`IOPC_P1_W-1:0];
   assign port3_pin_o  = drv_q[1].o;
   assign port3_pin_oe = drv_q[1].oe;
   assign port4_pin_o  = drv_q[2].o[`IOPC_P4_W-1:0];
   assign port4_pin_oe = drv_q[2].oe[`IOPC_P4_W-1:0];
   assign port6_pin_o  = drv_q[3].o[`IOPC_P6_W-1:0];
   assign port6_pin_oe = drv_q[3].oe[`IOPC_P6_W-1:0]; // [R8]

   // Shared pin feeds the interrupt path when selected
   assign ext_irq_pin_select = irqsel_ff;
   assign external_irq_zero  = irqsel_ff & syn_q[0][0]; // [R12]
endmodule : iopc_core

// ===== hw/iopc_cfg.svh
// Purpose: Constants for the I/O port core (addresses, widths, resets)
// Assumes: 16-bit CPU address, 8-bit data
// Notes:   Types live in iopc_pkg
// What this block does
// [R1] Output latch holds written value until rewritten
// [R2] Reads return live pin level, no copy; code reads pins through a two-flop synchronizer
// [R3] Outside holds inputs stable or software rereads
// [R4] Pins sampled in S1 of read cycle; S1 loads the synchronizer output, pin level from two clocks earlier
// [R5] Written data reaches pin in S2; latch loads at end of S2, pin driver at end of S3
// [R6] Read-modify-write reads return output latch contents
// [R7] Other reads return actual pin level
// [R8] Four ports, 19 pins: 1,8,6,4 bits
// [R9] Direction register selects port one mode
// [R10] Port one direction clears to input
// [R11] Port one output latch clears to zero
// [R12] Port one pin shared with external interrupt
// [R13] Software avoids read-modify-write on write-only registers
// [R14] Software avoids reserved and inaccessible addresses
// [R15] Interrupt use keeps port one as input
// [R16] Port three open-drain bits reset to tri-state
// [R17] Direction one drives latch, zero disables driver
`ifndef IOPC_CFG_SVH
`define IOPC_CFG_SVH
`define IOPC_AW           16
`define IOPC_DW           8
`define IOPC_P1_W         1
`define IOPC_P3_W         8
`define IOPC_P4_W         6
`define IOPC_P6_W         4
`define IOPC_A_P1DATA     16'h0001
`define IOPC_A_P3DATA     16'h0003
`define IOPC_A_P4DATA     16'h0004
`define IOPC_A_P6DATA     16'h0006
`define IOPC_A_P1DIR      16'h000B
`define IOPC_A_IRQSEL     16'h0037
`define IOPC_IRQSEL_BIT   6
`define IOPC_A_PORT3_OPEN_DRAIN_SELECT      16'h1F83
`define IOPC_A_PORT4_OPEN_DRAIN_SELECT      16'h1F84
`define IOPC_A_P3DIR      16'h1F89
`define IOPC_A_P4DIR      16'h1F8A
`define IOPC_A_P6DIR      16'h1F8C
`define IOPC_RST_BYTE     8'h00
`define IOPC_ZERO_BYTE    8'h00
`endif

// ===== hw/iopc_pkg.sv
// Purpose: Types for the I/O port core
// Assumes: iopc_cfg.svh constants
// Notes:   CPU access phase carried as an enum
`include "iopc_cfg.svh"
package iopc_pkg;
   typedef enum logic [1:0] {IOPC_IDLE, IOPC_S1, IOPC_S2, IOPC_S3} iopc_state_t;
   typedef struct packed {
      logic [`IOPC_AW-1:0] addr;
      logic                rd;
      logic                wr;
      logic                rmw;
      logic [`IOPC_DW-1:0] wdata;
   } iopc_req_t;
   typedef struct packed {
      logic [`IOPC_DW-1:0] o;
      logic [`IOPC_DW-1:0] oe;
   } iopc_drv_t;
endpackage : iopc_pkg

// ===== hw/iopc_port.sv
// Purpose: One I/O port: latch, direction, open-drain select, pin sync
// Assumes: Unused upper bits are tied off by the caller
// Notes:   Open-drain drives low only
`timescale 1ns/100ps
`include "iopc_cfg.svh"
module iopc_port
   import iopc_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                latch_we,
   input  wire logic                dir_we,
   input  wire logic                od_we,
   input  wire logic [`IOPC_DW-1:0] wdata,
   input  wire logic [`IOPC_DW-1:0] pin_i,
   output      logic [`IOPC_DW-1:0] latch_q,
   output      logic [`IOPC_DW-1:0] dir_q,
   output      logic [`IOPC_DW-1:0] od_q,
   output      logic [`IOPC_DW-1:0] pin_sync,
   output      iopc_drv_t           drv
);
   logic [`IOPC_DW-1:0] latch_ff, nxt_latch;
   logic [`IOPC_DW-1:0] dir_ff, nxt_dir;
   logic [`IOPC_DW-1:0] od_ff, nxt_od;
   logic [`IOPC_DW-1:0] meta_ff, sync_ff;
   iopc_drv_t           drv_ff, nxt_drv;

   always_comb
   begin
      nxt_latch = latch_we ? wdata : latch_ff; // [R1]
      nxt_dir   = dir_we ? wdata : dir_ff;     // [R9]
      nxt_od    = od_we ? wdata : od_ff;
   end

   genvar i;
   generate
      for (i = 0; i < `IOPC_DW; i++)
      begin : g_bit
         // Open-drain: drive only a low; tri-state: drive latch
         assign nxt_drv.o[i]  = od_ff[i] ? 1'b0 : latch_ff[i];
         assign nxt_drv.oe[i] = dir_ff[i] & (~od_ff[i] | ~latch_ff[i]); // [R17]
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         latch_ff <= `IOPC_RST_BYTE; // [R11]
         dir_ff   <= `IOPC_RST_BYTE; // [R10]
         od_ff    <= `IOPC_RST_BYTE; // [R16]
         drv_ff   <= '0;
         meta_ff  <= `IOPC_RST_BYTE;
         sync_ff  <= `IOPC_RST_BYTE;
      end
      else
      begin
         latch_ff <= nxt_latch;
         dir_ff   <= nxt_dir;
         od_ff    <= nxt_od;
         drv_ff   <= nxt_drv;
         meta_ff  <= pin_i;
         sync_ff  <= meta_ff;
      end
   end

   assign latch_q  = latch_ff;
   assign dir_q    = dir_ff;
   assign od_q     = od_ff;
   assign pin_sync = sync_ff;
   assign drv      = drv_ff;
endmodule : iopc_port

// ===== test/iopc_core_asserts.sv
// Purpose: Port core timing checks
// Assumes: One access at a time
// Notes:   Bound from the bench top
`timescale 1ns/100ps
`include "iopc_cfg.svh"
module iopc_core_asserts
   import iopc_pkg::*;
(
   input wire logic                  clk,
   input wire logic                  rst,
   input wire iopc_req_t             req,
   input wire logic [`IOPC_DW-1:0]   rdata,
   input wire logic                  rvalid,
   input wire logic                  wdone,
   input wire logic [`IOPC_P1_W-1:0] port1_bit_zero_pin_o,
   input wire logic [`IOPC_P3_W-1:0] port3_pin_oe,
   input wire logic                  external_irq_zero,
   input wire logic                  ext_irq_pin_select
);
   logic [1:0] ph_ff;
   logic [1:0] nxt_ph;
   always_comb
   begin
      nxt_ph = ph_ff + 2'h1;
      if (ph_ff == 2'h0)
         nxt_ph = {1'b0, req.rd | req.wr};
      if (rst)
         nxt_ph = 2'h0;
   end
   always_ff @(posedge clk)
   begin
      ph_ff <= nxt_ph;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_rd;
      ph_ff == 2'h0 && req.rd;
   endsequence
   sequence s_wr;
      ph_ff == 2'h0 && req.wr && !req.rd;
   endsequence
   AST_RD_ANSWER: assert property (s_rd |-> !rvalid ##2 rvalid ##1 !rvalid)
      else $error("read answer out of place");
   AST_WR_DONE: assert property (s_wr |-> ##3 wdone)
      else $error("write done late");
   AST_RDATA_HOLD: assert property ($changed(rdata) |-> ph_ff == 2'h2)
      else $error("read data moved outside a read");
   AST_LATCH_HOLD: assert property ($changed(port1_bit_zero_pin_o) |-> $past(wdone))
      else $error("pin value moved without a write");
   AST_OE_HOLD: assert property ($changed(port3_pin_oe) |-> $past(wdone))
      else $error("pin enable moved without a write");
   AST_RESET_VAL: assert property ($past(rst) |-> port3_pin_oe == 0
      && port1_bit_zero_pin_o == 0 && rdata == 0 && !ext_irq_pin_select)
      else $error("reset values wrong");
   AST_IRQ_GATE: assert property (!ext_irq_pin_select && !$past(ext_irq_pin_select)
      |-> !external_irq_zero)
      else $error("irq seen while pin is a port");
   AST_ONE_ANSWER: assert property (rvalid |-> !wdone)
      else $error("read and write answers together");
endmodule : iopc_core_asserts

// ===== test/iopc_pin_model.sv
// Purpose: Outside circuit on one port
// Assumes: Drives only where the port releases
// Notes:   Level is driver or outside value
`timescale 1ns/100ps
module iopc_pin_model
#(
   parameter int W = 8
)
(
   input  wire logic [W-1:0] pin_o,
   input  wire logic [W-1:0] pin_oe,
   input  wire logic [W-1:0] ext_val,
   output      logic [W-1:0] pin_lvl
);
   assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext_val);
endmodule : iopc_pin_model

// ===== test/test_io_port_core.sv
// Purpose: Port core bench
// Assumes: Four cycle access spacing
// Notes:   Read answers checked from a queue
`timescale 1ns/100ps
`include "iopc_cfg.svh"
module test_io_port_core;
   import iopc_pkg::*;
   localparam int          WT [4] = '{1, 8, 6, 4};
   localparam logic [15:0] DA [4] = '{`IOPC_A_P1DATA, `IOPC_A_P3DATA, `IOPC_A_P4DATA, `IOPC_A_P6DATA};
   localparam logic [15:0] CA [4] = '{`IOPC_A_P1DIR, `IOPC_A_P3DIR, `IOPC_A_P4DIR, `IOPC_A_P6DIR};
   logic       clk, rst, rvalid, wdone, irq, irq_sel;
   iopc_req_t  req;
   logic [7:0] rdata, dv, lv, mk;
   logic [7:0] ext [4];
   wire  [7:0] po [4], poe [4], lvl [4];
   int         errors, num_checks, seed;
   logic [7:0] expq [$];
   iopc_core iopc_core_inst (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
      .wdone(wdone), .port1_bit_zero_pin_i(lvl[0][0:0]), .port1_bit_zero_pin_o(po[0][0:0]),
      .port1_bit_zero_pin_oe(poe[0][0:0]), .external_irq_zero(irq), .ext_irq_pin_select(irq_sel),
      .port3_pin_i(lvl[1]), .port3_pin_o(po[1]), .port3_pin_oe(poe[1]),
      .port4_pin_i(lvl[2][5:0]), .port4_pin_o(po[2][5:0]), .port4_pin_oe(poe[2][5:0]),
      .port6_pin_i(lvl[3][3:0]), .port6_pin_o(po[3][3:0]), .port6_pin_oe(poe[3][3:0]));
   for (genvar g = 0; g < 4; g++)
   begin : g_pin
      iopc_pin_model #(.W(WT[g])) iopc_pin_model_inst (.pin_o(po[g][WT[g]-1:0]),
         .pin_oe(poe[g][WT[g]-1:0]), .ext_val(ext[g][WT[g]-1:0]), .pin_lvl(lvl[g][WT[g]-1:0]));
   end
   task tally_and_finish;
      $display("errors %0d checks %0d", errors, num_checks);
      if (errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task bus(input logic [15:0] a, input logic r, input logic m, input logic [7:0] d,
            input logic [7:0] e);
      int n;
      @(negedge clk);
      if (r)
         expq.push_back(e);
      req = '{a, r, !r, m, d};
      for (n = 0; n < 6 && rvalid !== 1'b1 && wdone !== 1'b1; n++)
      begin
         @(posedge clk);
         #1;
      end
      if (n == 6)
      begin
         errors++;
         tally_and_finish;
      end
      @(negedge clk);
      req.rd = 1'b0;
      req.wr = 1'b0;
   endtask : bus
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   forever
   begin
      @(posedge clk);
      #1;
      if (rvalid === 1'b1)
         chk("rdata", expq.pop_front(), rdata);
   end
   initial
   begin
      rst = 1'b1;
      req = '0;
      seed = 30;
      errors = 0;
      num_checks = 0;
      for (int i = 0; i < 4; i++)
         ext[i] = 8'h00;
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         mk = 8'hFF >> (8 - WT[i]);
         bus(CA[i], 1, 0, 0, 8'h00);
         bus(DA[i], 1, 1, 0, 8'h00);
         chk("oe", 8'h00, poe[i] & mk);
      end
      bus(`IOPC_A_PORT3_OPEN_DRAIN_SELECT, 1, 0, 0, 8'h00);
      bus(`IOPC_A_PORT4_OPEN_DRAIN_SELECT, 1, 0, 0, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         mk = 8'hFF >> (8 - WT[i]);
         dv = $random(seed);
         lv = $random(seed);
         bus(CA[i], 0, 0, dv, 8'h00);
         bus(DA[i], 0, 0, lv, 8'h00);
         @(negedge clk);
         chk("oe", dv & mk, poe[i] & mk);
         chk("o", dv & lv & mk, po[i] & dv & mk);
         for (int k = 0; k < 2; k++)
         begin
            @(negedge clk);
            ext[i] = $random(seed);
            repeat (3) @(negedge clk);
            bus(DA[i], 1, 0, 0, (dv & lv | ~dv & ext[i]) & mk);
         end
         bus(DA[i], 1, 1, 0, lv & mk);
         bus(CA[i], 1, 0, 0, dv & mk);
      end
      dv = $random(seed);
      bus(`IOPC_A_PORT3_OPEN_DRAIN_SELECT, 0, 0, dv, 8'h00);
      bus(`IOPC_A_PORT3_OPEN_DRAIN_SELECT, 1, 0, 0, dv);
      bus(`IOPC_A_P1DIR, 0, 0, 8'h00, 8'h00);
      bus(`IOPC_A_IRQSEL, 0, 0, 8'h40, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
         @(negedge clk);
         ext[0] = k[0] ? 8'h00 : 8'h01;
         repeat (4) @(negedge clk);
         chk("irq", {7'h00, ext[0][0]}, {7'h00, irq});
      end
      chk("sel", 8'h01, {7'h00, irq_sel});
      @(negedge clk);
      rst = 1'b1;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      bus(`IOPC_A_P3DIR, 1, 0, 0, 8'h00);
      tally_and_finish;
   end
endmodule : test_io_port_core
bind iopc_core iopc_core_asserts iopc_core_asserts_inst (.clk(clk), .rst(rst), .req(req),
   .rdata(rdata), .rvalid(rvalid), .wdone(wdone), .port1_bit_zero_pin_o(port1_bit_zero_pin_o),
   .port3_pin_oe(port3_pin_oe), .external_irq_zero(external_irq_zero),
   .ext_irq_pin_select(ext_irq_pin_select));
